// ### serial_port_command_handler.sv
// Command interpreter for one serial port, plus its byte FIFO.
// Assumes command bytes, UART strobes and responses all share clk.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Byte FIFO, first word fall-through
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // Storage
   logic [AW:0] wr_ptr;             // Write pointer, wrap bit on top
   logic [AW:0] rd_ptr;             // Read pointer, wrap bit on top
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // Full when pointers differ only in the wrap bit
   assign count = wr_ptr - rd_ptr;
   assign in_ready = (count != (AW + 1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Pointer update
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Data store, no reset needed
   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Command handler top
module serial_port_command_handler import serial_cmd_pkg::*; #(
   parameter int lamp_cycles = LAMP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   // Command datagram stream
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_last,
   input wire logic [15:0] cmd_length,
   // Response datagram stream
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [7:0] rsp_data,
   output logic rsp_last,
   // Port state from the open/close logic
   input wire logic port_open,
   input wire logic [7:0] port_status,
   // UART transmit side
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   // UART receive side
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   input wire logic rx_fault,
   // Configuration and lamp
   output logic [15:0] baud_divisor,
   output logic [7:0] line_attributes,
   output logic [7:0] indicator_event_mask,
   output logic lamp
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   seq_type state;                    // Sequencer state
   seq_type next_state;               // Its next value
   logic [7:0] opcode;                // Opcode of command in hand
   logic reject;                      // Reject flag for the reply
   logic [2:0] idx;                   // Parameter byte index, saturating
   logic [7:0] shadow [4];            // Configure bytes until committed
   logic [15:0] reply_length_limit;   // Receive limit, low byte first
   logic [15:0] remaining;            // Data bytes still to reply
   logic [LAMP_CNT_W-1:0] lamp_cnt;   // Lamp on-time left
   logic [4:0] tx_count;              // Transmit buffer fill
   logic [4:0] rx_count;              // Receive buffer fill
   logic tx_in_ready;                 // Transmit buffer has room
   logic [7:0] rx_out_data;           // Head of receive buffer
   logic rx_out_valid;                // Receive buffer not empty

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire cmd_take = cmd_valid & cmd_ready;
   wire slot_free = !rsp_valid | rsp_ready;
   wire is_cfg = (opcode == OP_CONFIGURE);
   wire is_tx = (opcode == OP_TRANSMIT);
   wire is_rx = (opcode == OP_RECEIVE);
   // Payload size is datagram size less the opcode byte
   wire [15:0] payload_len = cmd_length - 16'h0001;
   wire [15:0] tx_free = 16'(FIFO_DEPTH) - {11'h000, tx_count};
   wire [15:0] rx_avail = {11'h000, rx_count};
   // Whole string must fit or nothing is queued
   wire tx_short = payload_len > tx_free;
   // Opcode byte decides most rejects up front
   wire first_reject = (cmd_data == OP_CONFIGURE) ? (port_open | cmd_last) :
                       (cmd_data == OP_TRANSMIT) ? tx_short :
                       (cmd_data == OP_RECEIVE) ? 1'b0 : 1'b1;
   // Every byte after the opcode of an accepted transmit goes out raw
   wire tx_wr = cmd_take & (state == GATHER) & is_tx & !reject;
   // Smaller of limit and unread bytes
   wire [15:0] reply_n = (reply_length_limit < rx_avail) ? reply_length_limit :
                         rx_avail;
   wire [15:0] stat_n = (is_rx & !reject) ? reply_n : 16'h0000;
   // Returned bytes are popped from the receive buffer
   wire rx_pop = (state == DATA) & slot_free;
   wire [7:0] status_byte = reject ? (port_status | REJECT_MASK) :
                            (port_status & ~REJECT_MASK);
   wire commit = (state == STAT) & slot_free & is_cfg & !reject;
   // Selected events only; any mix allowed
   wire tx_event = tx_valid & tx_ready & indicator_event_mask[TX_EVENT_BIT];
   wire rx_event = rx_valid & rx_ready & indicator_event_mask[RX_EVENT_BIT];
   wire fault_event = rx_fault & indicator_event_mask[FAULT_EVENT_BIT];
   wire lamp_event = tx_event | rx_event | fault_event;

   ////////////////////////////////////////////////////////////////////////////
   // Buffers
   // Queued bytes leave before new ones
   byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(tx_wr),
      .in_ready(tx_in_ready),
      .in_data(cmd_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data),
      .count(tx_count)
   );

   // Receive buffer; full back-pressures the UART
   byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rx_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_data),
      .out_valid(rx_out_valid),
      .out_ready(rx_pop),
      .out_data(rx_out_data),
      .count(rx_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         IDLE: begin
            if (cmd_take) next_state = cmd_last ? STAT : GATHER;
         end
         GATHER: begin
            if (cmd_take && cmd_last) next_state = STAT;
         end
         // Status byte first, then data
         STAT: begin
            if (slot_free) next_state = (stat_n != 16'h0000) ? DATA : IDLE;
         end
         DATA: begin
            if (slot_free && remaining == 16'h0001) next_state = IDLE;
         end
      endcase
   end

   // State and command ready, both registered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= IDLE;
         cmd_ready <= 1'b0;
      end else begin
         state <= next_state;
         cmd_ready <= (next_state == IDLE) | (next_state == GATHER);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command capture: opcode, reject, parameter bytes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opcode <= 8'h00;
         reject <= 1'b0;
         idx <= 3'h0;
         reply_length_limit <= 16'h0000;
      end else if (cmd_take && state == IDLE) begin
         opcode <= cmd_data;
         reject <= first_reject;
         idx <= 3'h0;
         reply_length_limit <= 16'h0000;
      end else if (cmd_take && state == GATHER) begin
         if (idx != 3'h7) idx <= idx + 3'h1;
         // Short or long configure never applies
         if (is_cfg && cmd_last && idx != CONFIG_LAST_IDX) reject <= 1'b1;
         if (is_rx && idx == 3'h0) reply_length_limit[7:0] <= cmd_data;
         if (is_rx && idx == 3'h1) reply_length_limit[15:8] <= cmd_data;
      end
   end

   // Configure bytes held until the whole command checks out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow <= '{default: 8'h00};
      end else if (cmd_take && state == GATHER && is_cfg && idx <= CONFIG_LAST_IDX) begin
         shadow[idx[1:0]] <= cmd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers; open port leaves them untouched
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_divisor <= DIVISOR_RESET;
         line_attributes <= ATTRIB_RESET;
         indicator_event_mask <= MASK_RESET;
      end else if (commit) begin
         baud_divisor <= {shadow[1], shadow[0]};
         line_attributes <= shadow[2];
         // Unused mask bits forced to zero
         indicator_event_mask <= shadow[3] & MASK_USED;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response stream: one register slot, loaded when free
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_last <= 1'b0;
         remaining <= 16'h0000;
      end else if (state == STAT && slot_free) begin
         rsp_valid <= 1'b1;
         rsp_data <= status_byte;
         rsp_last <= (stat_n == 16'h0000);
         remaining <= stat_n;
      end else if (rx_pop) begin
         // Count latched at status time caps the data
         rsp_valid <= 1'b1;
         rsp_data <= rx_out_data;
         rsp_last <= (remaining == 16'h0001);
         remaining <= remaining - 16'h0001;
      end else if (rsp_ready) begin
         rsp_valid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lamp timer; a fresh event reloads the full on-time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lamp_cnt <= '0;
         lamp <= 1'b0;
      end else if (lamp_event) begin
         lamp_cnt <= LAMP_CNT_W'(lamp_cycles - 1);
         lamp <= 1'b1;
      end else begin
         if (lamp_cnt != '0) lamp_cnt <= lamp_cnt - 1'b1;
         lamp <= (lamp_cnt != '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   mask_fixed_zero_a: assert property (
      @(posedge clk) disable iff (!rst_n) (indicator_event_mask & ~MASK_USED) == 8'h00)
      else $error("reserved indicator mask bit set");

   open_cfg_kept_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state == STAT && slot_free && is_cfg && reject) |=>
      $stable(indicator_event_mask) && $stable(baud_divisor) && rsp_data[7])
      else $error("rejected configure changed settings");

   lamp_lights_a: assert property (
      @(posedge clk) disable iff (!rst_n) lamp_event |=> lamp [*8])
      else $error("lamp not lit after event");

   lamp_restart_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      lamp_event |=> lamp_cnt == LAMP_CNT_W'(lamp_cycles - 1))
      else $error("lamp on-time not restarted");

   // Written from the pins, not from lamp_event, so a wrong mask bit shows
   rx_lamp_on_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rx_valid && rx_ready && indicator_event_mask[RX_EVENT_BIT]) |=> lamp)
      else $error("receive event left lamp dark");

   fault_lamp_on_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rx_fault && indicator_event_mask[FAULT_EVENT_BIT]) |=> lamp)
      else $error("fault event left lamp dark");

   tx_space_check_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cmd_take && state == IDLE && cmd_data == OP_TRANSMIT && tx_short) |=>
      reject ##1 !tx_wr [*3])
      else $error("oversized transmit not rejected");

   tx_write_room_a: assert property (
      @(posedge clk) disable iff (!rst_n) tx_wr |-> tx_in_ready && !reject)
      else $error("transmit write without room");

   rx_limit_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == DATA |-> remaining <= reply_length_limit && rx_out_valid)
      else $error("reply exceeds limit or buffer");

   rx_reply_len_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state == STAT && slot_free && is_rx && !reject) |=> remaining == $past(reply_n))
      else $error("reply length not the smaller count");

   rx_pop_drop_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rx_pop && !(rx_valid && rx_ready)) |=> rx_count == $past(rx_count) - 5'h01)
      else $error("returned byte left in buffer");

   status_first_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state == STAT && slot_free) |=> rsp_valid && rsp_data[6:0] == $past(port_status[6:0]))
      else $error("reply does not start with status");
endmodule

// ### serial_cmd_pkg.sv
// Constants, field layouts and state type for the serial port command handler.
// Assumes one 100 MHz clock domain shared by the datagram layer and the UART.
package serial_cmd_pkg;

   // Command opcodes
   localparam logic [7:0] OP_CONFIGURE = 8'h00;
   localparam logic [7:0] OP_TRANSMIT = 8'h01;
   localparam logic [7:0] OP_RECEIVE = 8'h02;

   // Indicator event mask layout
   localparam int TX_EVENT_BIT = 3;
   localparam int RX_EVENT_BIT = 2;
   localparam int FAULT_EVENT_BIT = 1;
   localparam logic [7:0] MASK_USED = 8'h0e;
   localparam logic [7:0] MASK_RESET = 8'h04;

   // Status byte: reject flag position
   localparam logic [7:0] REJECT_MASK = 8'h80;

   // Configuration defaults, index of the last parameter byte
   localparam logic [15:0] DIVISOR_RESET = 16'h0000;
   localparam logic [7:0] ATTRIB_RESET = 8'h00;
   localparam logic [2:0] CONFIG_LAST_IDX = 3'h3;

   // Buffers
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 8;

   // Lamp on-time
   localparam int CLK_MHZ = 100;
   localparam int LAMP_TIME_MS = 100;
   localparam int LAMP_CYCLES = LAMP_TIME_MS * 1000 * CLK_MHZ;
   localparam int LAMP_CNT_W = 24;

   // Command sequencer states
   typedef enum logic [2:0] {IDLE, GATHER, STAT, DATA} seq_type;

endpackage

// ### uart_far_end.sv
// Far-end model of the UART lines: sinks transmitted bytes, offers received ones.
// Assumes the bench calls its tasks from the clk domain of the command handler.
`timescale 1ns/1ps

module uart_far_end (
   input wire logic clk,
   input wire logic hold_tx,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic rx_fault
);
   // Bytes seen leaving the handler, in wire order
   logic [7:0] sent_q[$];

   // Stall on request so the transmit buffer can be filled
   assign tx_ready = !hold_tx;

   ////////////////////////////////////////////////////////////////////////
   // Capture each transmitted character
   always @(posedge clk) begin
      if (tx_valid && tx_ready) begin
         sent_q.push_back(tx_data);
      end
   end

   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_fault = 1'b0;
   end

   // Offer one received byte; held until taken, then the data goes stale
   task automatic put_rx(input logic [7:0] b);
      @(posedge clk);
      #1 rx_valid = 1'b1;
      rx_data = b;
      do @(posedge clk); while (!rx_ready);
      #1 rx_valid = 1'b0;
      rx_data = ~b; // Inverse, so a late sample never looks valid
   endtask

   // One-cycle line fault (break or character error)
   task automatic pulse_fault();
      @(posedge clk);
      #1 rx_fault = 1'b1;
      @(posedge clk);
      #1 rx_fault = 1'b0;
   endtask
endmodule

// ### test_serial_port_command_handler.sv
// Self-checking bench for the serial port command handler.
// Assumes the handler's FIFO depth of 16 and a short lamp time of 20 cycles.
`timescale 1ns/1ps

`define check(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", name, exp, got); end end

module test_serial_port_command_handler;
   import serial_cmd_pkg::*;

   logic clk, rst_n, cmd_valid, cmd_ready, cmd_last, rsp_valid, rsp_last, port_open;
   logic tx_valid, tx_ready, rx_valid, rx_ready, rx_fault, lamp, hold_tx;
   logic [7:0] cmd_data, rsp_data, port_status, tx_data, rx_data, line_attributes;
   logic [7:0] indicator_event_mask;
   logic rsp_ready, stall_rsp; // Response sink ready, and whether it stalls every other cycle
   logic [15:0] cmd_length, baud_divisor;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [7:0] pay[$];

   serial_port_command_handler #(.lamp_cycles(20)) u_serial_port_command_handler (
      .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_length(cmd_length),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last),
      .port_open(port_open), .port_status(port_status), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .rx_fault(rx_fault), .baud_divisor(baud_divisor),
      .line_attributes(line_attributes), .indicator_event_mask(indicator_event_mask),
      .lamp(lamp));

   uart_far_end u_uart_far_end (
      .clk(clk), .hold_tx(hold_tx), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_fault(rx_fault));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // A hung handshake ends the run as a failure
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (fail_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Send one datagram, collect the reply and compare it byte for byte
   task automatic run_cmd(input logic [7:0] b[$], input logic [7:0] e[$]);
      logic [7:0] r[$];
      int n;
      cmd_length = 16'(b.size()); // Length is the datagram size
      foreach (b[i]) begin
         cmd_valid = 1'b1;
         cmd_data = b[i];
         cmd_last = (i == b.size() - 1);
         do @(posedge clk); while (!cmd_ready);
         #1;
      end
      cmd_valid = 1'b0;
      cmd_last = 1'b0;
      n = 0;
      while (n < 64) begin
         @(posedge clk);
         n++;
         // A byte is handed off only where valid meets ready
         if (rsp_valid && rsp_ready) begin
            r.push_back(rsp_data);
            if (rsp_last) break;
         end
         #1 rsp_ready = !stall_rsp || !rsp_ready;
      end
      #1 rsp_ready = 1'b1;
      `check("rsp_size", e.size(), r.size())
      foreach (e[i]) if (i < r.size()) `check("rsp_byte", e[i], r[i])
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_last = 1'b0;
      cmd_data = 8'h00;
      cmd_length = 16'h0000;
      port_open = 1'b0;
      port_status = 8'h21; // Arbitrary pass-through status bits
      hold_tx = 1'b0;
      rsp_ready = 1'b1;
      stall_rsp = 1'b0;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      `check("mask_reset", 8'h04, indicator_event_mask)
      `check("lamp_reset", 1'b0, lamp)
      // Closed port: configure applies, fault only
      run_cmd('{8'h00, 8'h34, 8'h12, 8'ha5, 8'h02}, '{8'h21});
      `check("divisor", 16'h1234, baud_divisor)
      `check("attrib", 8'ha5, line_attributes)
      `check("mask_fault", 8'h02, indicator_event_mask)
      // Received byte is masked out, fault lights the lamp then times out
      u_uart_far_end.put_rx(8'h0d);
      repeat (5) @(posedge clk);
      `check("lamp_masked", 1'b0, lamp)
      u_uart_far_end.pulse_fault();
      repeat (2) @(posedge clk);
      `check("lamp_fault", 1'b1, lamp)
      repeat (30) @(posedge clk);
      `check("lamp_expired", 1'b0, lamp)
      // Open port refuses configuration and keeps the mask
      port_open = 1'b1;
      run_cmd('{8'h00, 8'h00, 8'h00, 8'h00, 8'h0c}, '{8'ha1});
      `check("mask_kept", 8'h02, indicator_event_mask)
      `check("divisor_kept", 16'h1234, baud_divisor)
      port_open = 1'b0;
      run_cmd('{8'h00, 8'h34, 8'h12, 8'ha5, 8'h0c}, '{8'h21});
      `check("mask_both", 8'h0c, indicator_event_mask)
      // Second event inside the on-time restarts it
      u_uart_far_end.put_rx(8'h41);
      repeat (2) @(posedge clk);
      `check("lamp_rx", 1'b1, lamp)
      repeat (13) @(posedge clk);
      u_uart_far_end.put_rx(8'h42);
      repeat (15) @(posedge clk);
      `check("lamp_restart", 1'b1, lamp)
      repeat (15) @(posedge clk);
      `check("lamp_done", 1'b0, lamp)
      u_uart_far_end.put_rx(8'h43);
      u_uart_far_end.put_rx(8'h44);
      // Five unread bytes: limit 2, then a limit above the count
      // Stalling sink, and a status whose top bit the clear reject flag overrides
      port_status = 8'h96;
      stall_rsp = 1'b1;
      run_cmd('{8'h02, 8'h02, 8'h00}, '{8'h16, 8'h0d, 8'h41});
      run_cmd('{8'h02, 8'h00, 8'h01}, '{8'h16, 8'h42, 8'h43, 8'h44});
      run_cmd('{8'h02, 8'h05, 8'h00}, '{8'h16});
      port_status = 8'h21;
      stall_rsp = 1'b0;
      // Stalled line: fill the buffer to exactly 16, an overflow in between
      hold_tx = 1'b1;
      run_cmd('{8'h01, 8'h0d, 8'h00, 8'hff, 8'h0a, 8'h55}, '{8'h21});
      pay = '{8'h01};
      repeat (12) pay.push_back(8'h77);
      run_cmd(pay, '{8'ha1});
      pay = '{8'h01};
      for (int i = 0; i < 11; i++) pay.push_back(8'h60 + 8'(i));
      run_cmd(pay, '{8'h21});
      repeat (30) @(posedge clk);
      `check("lamp_idle", 1'b0, lamp)
      `check("nothing_sent", 0, u_uart_far_end.sent_q.size())
      #1 hold_tx = 1'b0;
      repeat (5) @(posedge clk);
      `check("lamp_tx", 1'b1, lamp)
      repeat (30) @(posedge clk);
      pay = '{8'h0d, 8'h00, 8'hff, 8'h0a, 8'h55};
      for (int i = 0; i < 11; i++) pay.push_back(8'h60 + 8'(i));
      `check("sent_count", 16, u_uart_far_end.sent_q.size())
      foreach (pay[i]) `check("sent_byte", pay[i], u_uart_far_end.sent_q[i])
      // Short configure and an unknown opcode are refused, settings kept
      #1;
      run_cmd('{8'h00, 8'h11, 8'h22, 8'h33}, '{8'ha1});
      `check("mask_short", 8'h0c, indicator_event_mask)
      `check("divisor_short", 16'h1234, baud_divisor)
      run_cmd('{8'h07}, '{8'ha1});
      // Reset in mid-run brings back the defaults, then a command still works
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `check("mask_rerst", 8'h04, indicator_event_mask)
      `check("lamp_rerst", 1'b0, lamp)
      rst_n = 1'b1;
      run_cmd('{8'h02, 8'h04, 8'h00}, '{8'h21});
      wrap_up();
   end
endmodule
